// >>> rtl/ptc_pkg.sv
// Package for the paired timer control block: register map, fields, resets.
// Assumes a 32-bit APB with word-aligned registers.
package ptc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] PTC_OFF_CTRL     = 8'h00;
	localparam logic [7:0] PTC_OFF_UCTRL    = 8'h04;
	localparam logic [7:0] PTC_OFF_PER_LO   = 8'h08;
	localparam logic [7:0] PTC_OFF_PER_HI   = 8'h0C;
	localparam logic [7:0] PTC_OFF_CNT_LO   = 8'h10;
	localparam logic [7:0] PTC_OFF_CNT_HI   = 8'h14;
	localparam logic [7:0] PTC_OFF_IRQ_STAT = 8'h18;
	localparam logic [7:0] PTC_OFF_IRQ_MASK = 8'h1C;

	// ----------------------------------------------------------------
	// Control field positions and masks
	// ----------------------------------------------------------------
	localparam int PTC_BIT_RUN   = 15;
	localparam int PTC_BIT_IDLE  = 13;
	localparam int PTC_BIT_GATE  = 6;
	localparam int PTC_BIT_PS_LO = 4;
	localparam int PTC_BIT_JOIN  = 3;
	localparam int PTC_BIT_CKSRC = 1;
	localparam logic [15:0] PTC_CTRL_WMASK  = 16'hA07A;
	localparam logic [15:0] PTC_UCTRL_WMASK = 16'hA072;
	localparam logic [15:0] PTC_CTRL_RESET  = 16'h0000;
	localparam logic [15:0] PTC_PER_RESET   = 16'hFFFF;

	// Interrupt status bits: low match, high match (also 32-bit match)
	localparam int PTC_IRQ_LO = 0;
	localparam int PTC_IRQ_HI = 1;

	// Prescale terminal counts for 1, 8, 64, 256
	localparam logic [7:0] PTC_PS_DIV1   = 8'h00;
	localparam logic [7:0] PTC_PS_DIV8   = 8'h07;
	localparam logic [7:0] PTC_PS_DIV64  = 8'h3F;
	localparam logic [7:0] PTC_PS_DIV256 = 8'hFF;

	// Decoded control word
	typedef struct packed {
		logic       run;
		logic       idle_stop;
		logic       gate_accumulate;
		logic [1:0] prescale_select;
		logic       pair_join;
		logic       clock_source_select;
	} ptc_ctrl_s;

	function automatic ptc_ctrl_s ptc_decode(input logic [15:0] w);
		ptc_ctrl_s c;
		c.run                 = w[PTC_BIT_RUN];
		c.idle_stop           = w[PTC_BIT_IDLE];
		c.gate_accumulate     = w[PTC_BIT_GATE];
		c.prescale_select     = w[PTC_BIT_PS_LO +: 2];
		c.pair_join           = w[PTC_BIT_JOIN];
		c.clock_source_select = w[PTC_BIT_CKSRC];
		return c;
	endfunction : ptc_decode

endpackage : ptc_pkg

// >>> rtl/ptc_tick.sv
// One 16-bit timer's tick path: source select, gate, idle stop, prescale.
// Assumes pin inputs are already synchronised to pclk.
`timescale 1ns/100ps
module ptc_tick
	import ptc_pkg::*;
(
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire ptc_ctrl_s ctrl,
	input  wire logic      idle_mode,
	input  wire logic      pin_s,
	input  wire logic      pin_rise,
	output logic           tick
);
	logic [7:0] div_r;
	logic [7:0] div_nxt;
	logic [7:0] term;
	logic       src;
	logic       halt;

	// ----------------------------------------------------------------
	// Source qualification
	// ----------------------------------------------------------------
	always_comb
	begin
		case (ctrl.prescale_select)
			2'b00:   term = PTC_PS_DIV1;
			2'b01:   term = PTC_PS_DIV8;
			2'b10:   term = PTC_PS_DIV64;
			default: term = PTC_PS_DIV256;
		endcase
		halt = !ctrl.run || (ctrl.idle_stop && idle_mode);           // see R7 see R1
		if (ctrl.clock_source_select)
			src = pin_rise;                                          // see R4
		else if (ctrl.gate_accumulate)
			src = pin_s;                                             // see R2
		else
			src = 1'b1;                                              // see R4
		div_nxt = div_r;
		tick    = 1'b0;
		if (halt)
			div_nxt = 8'h00;                                         // Fresh division on restart
		else if (src)
		begin
			if (div_r >= term)
			begin
				div_nxt = 8'h00;
				tick    = 1'b1;                                      // see R6
			end
			else
				div_nxt = div_r + 8'h01;
		end
	end

	// Prescaler state
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			div_r <= 8'h00;
		else
			div_r <= div_nxt;

endmodule : ptc_tick

// >>> rtl/ptc_top.sv
// Paired 16-bit timers with APB registers, joinable into one 32-bit timer.
// Assumes a 20 MHz pclk; pins and idle_mode are asynchronous to it.
//
// Contract
// R1 - Idle-stop bit halts timer during Idle
// R2 - Gate bit counts only while gate active
// R3 - Join bit forms one 32-bit timer
// R4 - Source bit picks pin edges or pclk
// R5 - Unimplemented control bits read zero
// R6 - Prescale divides by 1, 8, 64, 256
// R7 - Run bit starts and stops timer
// R8 - Lower word low, upper word high
// R9 - Joined: upper control ignored, upper flag
`timescale 1ns/100ps
module ptc_top
	import ptc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        idle_mode,
	input  wire logic        external_count_pin,
	input  wire logic        upper_count_pin,
	output logic             irq
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [1:0] sync3_r;                                             // Idle level needs no edge stage
	logic [2:0] sync1_nxt;

	// First stage feeds only the second stage
	always_comb
	begin
		sync1_nxt = {idle_mode, upper_count_pin, external_count_pin};
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
			sync3_r <= 2'h0;
		end
		else
		begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r[1:0];
		end

	logic lo_rise;
	logic hi_rise;
	assign lo_rise = sync2_r[0] && !sync3_r[0];
	assign hi_rise = sync2_r[1] && !sync3_r[1];

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [15:0] ctrl_r,   ctrl_nxt;
	logic [15:0] uctrl_r,  uctrl_nxt;
	logic [15:0] per_lo_r, per_lo_nxt;
	logic [15:0] per_hi_r, per_hi_nxt;
	logic [15:0] cnt_lo_r, cnt_lo_nxt;
	logic [15:0] cnt_hi_r, cnt_hi_nxt;
	logic [1:0]  stat_r,   stat_nxt;
	logic [1:0]  mask_r,   mask_nxt;
	logic [31:0] rdata_r,  rdata_nxt;
	logic        err_r,    err_nxt;

	ptc_ctrl_s lo_ctrl;
	ptc_ctrl_s hi_ctrl;
	logic      tick_lo;
	logic      tick_hi;
	logic      joined;

	assign lo_ctrl = ptc_decode(ctrl_r);
	assign joined  = lo_ctrl.pair_join;                                  // see R3
	// Joined pair ignores the upper control word entirely
	assign hi_ctrl = joined ? '0 : ptc_decode(uctrl_r);                  // see R9

	// ----------------------------------------------------------------
	// Tick paths
	// ----------------------------------------------------------------
	ptc_tick u_tick_lo (
		.pclk      (pclk),
		.presetn   (presetn),
		.ctrl      (lo_ctrl),
		.idle_mode (sync2_r[2]),
		.pin_s     (sync2_r[0]),
		.pin_rise  (lo_rise),
		.tick      (tick_lo)
	);

	ptc_tick u_tick_hi (
		.pclk      (pclk),
		.presetn   (presetn),
		.ctrl      (hi_ctrl),
		.idle_mode (sync2_r[2]),
		.pin_s     (sync2_r[1]),
		.pin_rise  (hi_rise),
		.tick      (tick_hi)
	);

	// ----------------------------------------------------------------
	// APB access: one wait-free access phase
	// ----------------------------------------------------------------
	logic wr_en;
	logic rd_en;
	logic hit;
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign prdata  = rdata_r;
	assign pslverr = err_r && psel && penable;
	assign irq     = |(stat_r & mask_r);

	// Address decode and read mux
	always_comb
	begin
		hit       = 1'b1;
		rdata_nxt = rdata_r;
		if (paddr == PTC_OFF_CTRL)
			rdata_nxt = {16'h0000, ctrl_r};                          // see R5
		else if (paddr == PTC_OFF_UCTRL)
			rdata_nxt = {16'h0000, uctrl_r};
		else if (paddr == PTC_OFF_PER_LO)
			rdata_nxt = {16'h0000, per_lo_r};
		else if (paddr == PTC_OFF_PER_HI)
			rdata_nxt = {16'h0000, per_hi_r};
		else if (paddr == PTC_OFF_CNT_LO)
			rdata_nxt = {16'h0000, cnt_lo_r};
		else if (paddr == PTC_OFF_CNT_HI)
			rdata_nxt = {16'h0000, cnt_hi_r};
		else if (paddr == PTC_OFF_IRQ_STAT)
			rdata_nxt = {30'h00000000, stat_r};
		else if (paddr == PTC_OFF_IRQ_MASK)
			rdata_nxt = {30'h00000000, mask_r};
		else
		begin
			hit       = 1'b0;
			rdata_nxt = 32'h00000000;                                // Unmapped reads zero
		end
		if (!rd_en)
			rdata_nxt = rdata_r;
		err_nxt   = (psel && !penable) ? !hit : err_r;
	end

	// ----------------------------------------------------------------
	// Counters, compare, registers
	// ----------------------------------------------------------------
	logic [31:0] cnt32;
	logic [31:0] per32;
	logic        m32;
	logic        m_lo;
	logic        m_hi;
	logic [1:0]  ev;
	assign cnt32 = {cnt_hi_r, cnt_lo_r};                                 // see R8
	assign per32 = {per_hi_r, per_lo_r};                                 // see R8
	assign m32   = tick_lo && (cnt32 == per32);
	assign m_lo  = tick_lo && (cnt_lo_r == per_lo_r);
	assign m_hi  = tick_hi && (cnt_hi_r == per_hi_r);

	always_comb
	begin
		ctrl_nxt   = ctrl_r;
		uctrl_nxt  = uctrl_r;
		per_lo_nxt = per_lo_r;
		per_hi_nxt = per_hi_r;
		cnt_lo_nxt = cnt_lo_r;
		cnt_hi_nxt = cnt_hi_r;
		mask_nxt   = mask_r;
		ev         = 2'b00;
		// Counting
		if (joined)
		begin
			if (tick_lo)
			begin
				{cnt_hi_nxt, cnt_lo_nxt} = m32 ? 32'h00000000 : cnt32 + 32'h00000001; // see R3
				ev[PTC_IRQ_HI] = m32;                                // see R9
			end
		end
		else
		begin
			if (tick_lo)
				cnt_lo_nxt = m_lo ? 16'h0000 : cnt_lo_r + 16'h0001;
			if (tick_hi)
				cnt_hi_nxt = m_hi ? 16'h0000 : cnt_hi_r + 16'h0001;
			ev[PTC_IRQ_LO] = m_lo;
			ev[PTC_IRQ_HI] = m_hi;
		end
		stat_nxt = stat_r;
		// Software writes; counter writes override a same-cycle tick
		if (wr_en)
		begin
			if (paddr == PTC_OFF_CTRL)
				ctrl_nxt = pwdata[15:0] & PTC_CTRL_WMASK;            // see R5 see R7
			else if (paddr == PTC_OFF_UCTRL)
				uctrl_nxt = pwdata[15:0] & PTC_UCTRL_WMASK;
			else if (paddr == PTC_OFF_PER_LO)
				per_lo_nxt = pwdata[15:0];
			else if (paddr == PTC_OFF_PER_HI)
				per_hi_nxt = pwdata[15:0];
			else if (paddr == PTC_OFF_CNT_LO)
				cnt_lo_nxt = pwdata[15:0];
			else if (paddr == PTC_OFF_CNT_HI)
				cnt_hi_nxt = pwdata[15:0];
			else if (paddr == PTC_OFF_IRQ_STAT)
				stat_nxt = stat_r & ~pwdata[1:0];
			else if (paddr == PTC_OFF_IRQ_MASK)
				mask_nxt = pwdata[1:0];
		end
		stat_nxt = stat_nxt | ev;                                    // Set beats clear
	end

	// Register bank
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_r   <= PTC_CTRL_RESET;
			uctrl_r  <= PTC_CTRL_RESET;
			per_lo_r <= PTC_PER_RESET;
			per_hi_r <= PTC_PER_RESET;
			cnt_lo_r <= 16'h0000;
			cnt_hi_r <= 16'h0000;
			stat_r   <= 2'h0;
			mask_r   <= 2'h0;
			rdata_r  <= 32'h00000000;
			err_r    <= 1'b0;
		end
		else
		begin
			ctrl_r   <= ctrl_nxt;
			uctrl_r  <= uctrl_nxt;
			per_lo_r <= per_lo_nxt;
			per_hi_r <= per_hi_nxt;
			cnt_lo_r <= cnt_lo_nxt;
			cnt_hi_r <= cnt_hi_nxt;
			stat_r   <= stat_nxt;
			mask_r   <= mask_nxt;
			rdata_r  <= rdata_nxt;
			err_r    <= err_nxt;
		end

endmodule : ptc_top

// >>> verification/ptc_assertions.sv
// Checker of bus answers, readback and irq masking at ptc_top ports.
// Assumes zero-wait APB and the ptc_pkg register map.
`timescale 1ns/100ps
module ptc_assertions
	import ptc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] ctl_r, uct_r, plo_r;
	logic [1:0]  msk_r;
	wire         acc = psel && penable;
	wire         hit = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
	// Shadows of writable fields; reserved bits are never stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl_r <= PTC_CTRL_RESET;
			uct_r <= PTC_CTRL_RESET;
			plo_r <= PTC_PER_RESET;
			msk_r <= 2'h0;
		end
		else if (acc && pwrite)
		begin
			if (paddr == PTC_OFF_CTRL) ctl_r <= pwdata[15:0] & PTC_CTRL_WMASK;
			if (paddr == PTC_OFF_UCTRL) uct_r <= pwdata[15:0] & PTC_UCTRL_WMASK;
			if (paddr == PTC_OFF_PER_LO) plo_r <= pwdata[15:0];
			if (paddr == PTC_OFF_IRQ_MASK) msk_r <= pwdata[1:0];
		end
	end
	sequence s_rd(logic [7:0] a);
		acc && !pwrite && paddr == a;
	endsequence
	property p_ctl_rd; s_rd(PTC_OFF_CTRL) |-> prdata == {16'h0000, ctl_r}; endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
	property p_uct_rd; s_rd(PTC_OFF_UCTRL) |-> prdata == {16'h0000, uct_r}; endproperty
	a_uct_rd: assert property (p_uct_rd) else $error("upper readback wrong");
	property p_plo_rd; s_rd(PTC_OFF_PER_LO) |-> prdata == {16'h0000, plo_r}; endproperty
	a_plo_rd: assert property (p_plo_rd) else $error("period readback wrong");
	property p_msk_rd; s_rd(PTC_OFF_IRQ_MASK) |-> prdata == {30'h0, msk_r}; endproperty
	a_msk_rd: assert property (p_msk_rd) else $error("mask readback wrong");
	property p_unmap; acc && !hit |-> pslverr && (pwrite || prdata == 32'h0); endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_no_err; acc && hit |-> !pslverr; endproperty
	a_no_err: assert property (p_no_err) else $error("mapped access refused");
	property p_err_ph; !acc |-> !pslverr; endproperty
	a_err_ph: assert property (p_err_ph) else $error("error outside access");
	// Irq is combinational from mask_r and stat_r, so it follows the mask at once; the second cycle is margin
	property p_irq_off; msk_r == 2'h0 [*2] |-> !irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked irq raised");
endmodule : ptc_assertions

// >>> verification/ptc_pin_model.sv
// Far-side model: pulse trains on the two timer pins.
// Assumes its task is called just after a rising pclk edge.
`timescale 1ns/100ps
module ptc_pin_model (
	input  wire logic  pclk,
	output logic [1:0] pin
);
	initial pin = 2'b00;
	// 2 high, 2 low: never shorter than the sync can see; rests low
	task automatic pulses(input int n, input logic [1:0] sel);
		repeat (n)
		begin
			pin <= sel;
			repeat (2) @(posedge pclk);
			pin <= 2'b00;
			repeat (2) @(posedge pclk);
		end
	endtask : pulses
endmodule : ptc_pin_model

// >>> verification/testbench.sv
// Testbench: APB tests of the paired timers with a pin model.
// Assumes ptc_top, ptc_pin_model and ptc_assertions compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %0t: got %h, expected %h", $time, g, e); end end
module testbench;
	import ptc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, idle_mode = 1'b0, pready, pslverr, irq, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0]  pin;
	int          error_cnt = 0, check_count = 0, cyc = 0;
	int          dv[4] = '{1, 8, 64, 256};
	always #25 pclk = ~pclk;
	ptc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .idle_mode(idle_mode), .external_count_pin(pin[0]),
		.upper_count_pin(pin[1]), .irq(irq));
	ptc_pin_model pm_u (.pclk(pclk), .pin(pin));
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d});
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rchk
	// Count n pulses under control word c, then stop and recheck
	task automatic cnt_run(input logic [15:0] c, input int n, input logic [31:0] e);
		wr(PTC_OFF_CNT_LO, 16'h0000);
		wr(PTC_OFF_CTRL, c | 16'h8000);
		pm_u.pulses(n, 2'b01);
		repeat (4) @(posedge pclk);
		wr(PTC_OFF_CTRL, c);
		rchk(PTC_OFF_CNT_LO, e);
		pm_u.pulses(2, 2'b01);
		rchk(PTC_OFF_CNT_LO, e);
	endtask : cnt_run
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// Watchdog: whole run needs well under 10000 cycles
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(PTC_OFF_CTRL, 32'h0);
		rchk(PTC_OFF_PER_LO, 32'h0000FFFF);
		wr(PTC_OFF_CTRL, 16'hFFFF);
		rchk(PTC_OFF_CTRL, 32'h0000A07A);
		wr(PTC_OFF_UCTRL, 16'hFFFF);
		rchk(PTC_OFF_UCTRL, 32'h0000A072);
		wr(PTC_OFF_CTRL, 16'h0000);
		wr(PTC_OFF_UCTRL, 16'h0000);
		apb(1'b1, 8'h20, 32'hFFFFFFFF);
		`CHK(err, 1'b1)
		rchk(8'h20, 32'h0);
		$display("Register test done");
		for (int p = 0; p < 4; p++)
			cnt_run({10'h000, p[1:0], 4'h2}, 2 * dv[p], 32'h2);
		idle_mode <= 1'b1;
		cnt_run(16'h2002, 5, 32'h0);
		cnt_run(16'h0002, 5, 32'h5);
		idle_mode <= 1'b0;
		cnt_run(16'h0040, 3, 32'h6);
		cnt_run(16'h0042, 3, 32'h3);
		// Internal clock: one count per pclk edge while run is held
		cnt_run(16'h0000, 2, 32'hF);
		// Unjoined upper timer counts its own pin, lower stays put
		wr(PTC_OFF_UCTRL, 16'h8002);
		pm_u.pulses(3, 2'b10);
		repeat (4) @(posedge pclk);
		wr(PTC_OFF_UCTRL, 16'h0000);
		rchk(PTC_OFF_CNT_HI, 32'h3);
		rchk(PTC_OFF_CNT_LO, 32'hF);
		$display("Prescale, idle and gate tests done");
		// Upper pin pulses too: joined pair must ignore it
		wr(PTC_OFF_CNT_LO, 16'hFFFE);
		wr(PTC_OFF_CNT_HI, 16'h0000);
		wr(PTC_OFF_UCTRL, 16'h8002);
		wr(PTC_OFF_CTRL, 16'h800A);
		pm_u.pulses(3, 2'b11);
		repeat (4) @(posedge pclk);
		wr(PTC_OFF_CTRL, 16'h000A);
		rchk(PTC_OFF_CNT_LO, 32'h1);
		rchk(PTC_OFF_CNT_HI, 32'h1);
		wr(PTC_OFF_UCTRL, 16'h0000);
		wr(PTC_OFF_CNT_HI, 16'h0000);
		wr(PTC_OFF_PER_LO, 16'h0003);
		wr(PTC_OFF_PER_HI, 16'h0000);
		wr(PTC_OFF_IRQ_MASK, 16'h0002);
		cnt_run(16'h000A, 4, 32'h0);
		`CHK(irq, 1'b1)
		rchk(PTC_OFF_IRQ_STAT, 32'h2);
		wr(PTC_OFF_IRQ_MASK, 16'h0000);
		`CHK(irq, 1'b0)
		wr(PTC_OFF_IRQ_MASK, 16'h0002);
		wr(PTC_OFF_IRQ_STAT, 16'h0002);
		`CHK(irq, 1'b0)
		rchk(PTC_OFF_IRQ_STAT, 32'h0);
		$display("Join and interrupt test done");
		tally_and_finish();
	end
endmodule : testbench
bind ptc_top ptc_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr), .irq(irq));
